/* File: rtl/pie_top.sv */
// Interrupt event sources feeding the request queue
`timescale 1ns/100ps
`include "pie_cfg.svh"
module pie_top
   import pie_pkg::*;
#(
   parameter int TICK_CYCLES = `PIE_TICK_CYCLES
)(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Global control
   input wire logic global_irq_enable,
   // Timer sources
   input wire logic [`PIE_INTERVAL_W-1:0] timer0_interval,
   input wire logic [`PIE_INTERVAL_W-1:0] timer1_interval,
   input wire logic [`PIE_INTERVAL_W-1:0] timer2_interval,
   input wire logic timer0_event_enable,
   input wire logic timer1_event_enable,
   input wire logic timer2_event_enable,
   // Digital inputs and their edge enables
   input wire logic [`PIE_NUM_INPUTS-1:0] digital_input,
   input wire logic [`PIE_NUM_INPUTS-1:0] input_edge_enable,
   // Fast counter compare matches
   input wire logic [`PIE_NUM_COUNTERS-1:0] counter_match,
   input wire logic counter_match_enable,
   // Pulse train completion
   input wire logic pulse0_done,
   input wire logic pulse1_done,
   input wire logic pulse0_done_enable,
   input wire logic pulse1_done_enable,
   // Supply monitor
   input wire logic power_loss,
   input wire logic power_fail_enable,
   // Serial ports, one bit per port
   input wire logic [2:0] free_format_mode,
   input wire logic [2:0] char_tx_done,
   input wire logic [2:0] char_rx_done,
   input wire logic [2:0] frame_tx_done,
   input wire logic [2:0] frame_rx_done,
   // Serial event enables
   input wire logic port0_char_tx_enable,
   input wire logic port0_char_rx_enable,
   input wire logic port0_frame_tx_enable,
   input wire logic port0_frame_rx_enable,
   input wire logic port1_char_tx_enable,
   input wire logic port1_char_rx_enable,
   input wire logic port1_frame_tx_enable,
   input wire logic port1_frame_rx_enable,
   input wire logic port2_char_tx_enable,
   input wire logic port2_char_rx_enable,
   input wire logic port2_frame_tx_enable,
   input wire logic port2_frame_rx_enable,
   // Service handshake
   input wire logic service_done,
   input wire logic main_resumed,
   // Queue state
   output logic irq_pending,
   output logic [`PIE_EVT_W-1:0] irq_event,
   output logic [`PIE_LEVEL_W-1:0] queue_level,
   output logic queue_masked
);
   localparam logic [`PIE_PRESCALE_W-1:0] TICK_LAST = `PIE_PRESCALE_W'(TICK_CYCLES - 1);

   pie_top_state_type s;
   pie_top_state_type next_s;

   logic [`PIE_NUM_EVENTS-1:0] raw;
   logic [`PIE_NUM_EVENTS-1:0] allowed;
   logic [`PIE_NUM_EVENTS-1:0] fresh;
   logic [`PIE_NUM_EVENTS-1:0] taken;
   logic [`PIE_NUM_TIMERS-1:0] timer_fire;
   logic [`PIE_NUM_TIMERS-1:0] timer_enable;
   logic [`PIE_NUM_TIMERS-1:0][`PIE_INTERVAL_W-1:0] timer_interval;
   logic [1:0][3:0] port_enable;
   logic push_valid;
   logic push_ready;
   logic [`PIE_EVT_W-1:0] push_event;
   logic q_masked;

   assign timer_enable = {timer2_event_enable, timer1_event_enable, timer0_event_enable};
   assign timer_interval = {timer2_interval, timer1_interval, timer0_interval};
   assign port_enable[0] = {port0_frame_rx_enable, port0_frame_tx_enable,
                            port0_char_rx_enable, port0_char_tx_enable};
   assign port_enable[1] = {port1_frame_rx_enable, port1_frame_tx_enable,
                            port1_char_rx_enable, port1_char_tx_enable};

   // Timers carry their own enable; disabling one never reaches into the queue
   genvar t;
   generate
      for (t = 0; t < `PIE_NUM_TIMERS; t++) begin : g_timer
         pie_timer u_timer (
            .mclk(mclk),
            .rst(rst),
            .ce(ce),
            .tick(s.tick),
            .enable(timer_enable[t]),
            .interval(timer_interval[t]),
            .fire(timer_fire[t])
         );
         assign raw[`PIE_EVT_TIMER_BASE + t] = timer_fire[t];
         assign allowed[`PIE_EVT_TIMER_BASE + t] = 1'b1;
      end
   endgenerate

   // Inputs sampled on the millisecond tick: edges closer than 1 ms can merge
   genvar i;
   generate
      for (i = 0; i < `PIE_NUM_INPUTS; i++) begin : g_input
         assign raw[`PIE_EVT_RISE_BASE + i] =
            s.tick && digital_input[i] && !s.din_seen[i];
         assign raw[`PIE_EVT_FALL_BASE + i] =
            s.tick && !digital_input[i] && s.din_seen[i];
         assign allowed[`PIE_EVT_RISE_BASE + i] = input_edge_enable[i];
         assign allowed[`PIE_EVT_FALL_BASE + i] = input_edge_enable[i];
      end
   endgenerate

   genvar c;
   generate
      for (c = 0; c < `PIE_NUM_COUNTERS; c++) begin : g_counter
         assign raw[`PIE_EVT_COUNTER_BASE + c] = counter_match[c];
         assign allowed[`PIE_EVT_COUNTER_BASE + c] = counter_match_enable;
      end
   endgenerate

   assign raw[`PIE_EVT_PULSE0] = pulse0_done;
   assign raw[`PIE_EVT_PULSE1] = pulse1_done;
   assign allowed[`PIE_EVT_PULSE0] = pulse0_done_enable;
   assign allowed[`PIE_EVT_PULSE1] = pulse1_done_enable;

   // Supply loss is a level; only its onset makes an event
   assign raw[`PIE_EVT_POWER] = power_loss && !s.power_seen;
   assign allowed[`PIE_EVT_POWER] = power_fail_enable;

   // Ports 0 and 1 share one layout of four consecutive numbers
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port
         localparam int BASE = `PIE_EVT_PORT0_BASE + p * `PIE_EVT_PORT_STRIDE;
         assign raw[BASE + 0] = char_tx_done[p];
         assign raw[BASE + 1] = char_rx_done[p];
         assign raw[BASE + 2] = frame_tx_done[p];
         assign raw[BASE + 3] = frame_rx_done[p];
         assign allowed[BASE + 0] = free_format_mode[p] && port_enable[p][0];
         assign allowed[BASE + 1] = free_format_mode[p] && port_enable[p][1];
         assign allowed[BASE + 2] = free_format_mode[p] && port_enable[p][2];
         assign allowed[BASE + 3] = free_format_mode[p] && port_enable[p][3];
      end
   endgenerate

   // Port 2 borrows the two unused numbers between the edge groups
   assign raw[`PIE_EVT_P2_CHAR_TX] = char_tx_done[2];
   assign raw[`PIE_EVT_P2_CHAR_RX] = char_rx_done[2];
   assign raw[`PIE_EVT_P2_FRAME_TX] = frame_tx_done[2];
   assign raw[`PIE_EVT_P2_FRAME_RX] = frame_rx_done[2];
   assign allowed[`PIE_EVT_P2_CHAR_TX] = free_format_mode[2] && port2_char_tx_enable;
   assign allowed[`PIE_EVT_P2_CHAR_RX] = free_format_mode[2] && port2_char_rx_enable;
   assign allowed[`PIE_EVT_P2_FRAME_TX] = free_format_mode[2] && port2_frame_tx_enable;
   assign allowed[`PIE_EVT_P2_FRAME_RX] = free_format_mode[2] && port2_frame_rx_enable;

   // Enables other than the timer ones act only here, on arrival; queued entries are never revisited
   assign fresh = raw & allowed & {`PIE_NUM_EVENTS{global_irq_enable && !q_masked}};

   // Lowest pending number goes first, one per cycle
   always_comb begin
      push_valid = 1'b0;
      push_event = `PIE_RESET_EVT;
      taken = '0;
      for (int n = `PIE_NUM_EVENTS - 1; n >= 0; n--) begin
         if (s.pending[n]) begin
            push_valid = 1'b1;
            push_event = n[`PIE_EVT_W-1:0];
            taken = '0;
            taken[n] = 1'b1;
         end
      end
   end

   always_comb begin
      next_s = s;
      if (s.prescale == TICK_LAST) begin
         next_s.prescale = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.prescale = s.prescale + 16'h0001;
         next_s.tick = 1'b0;
      end
      if (s.tick) begin
         next_s.din_seen = digital_input;
      end
      next_s.power_seen = power_loss;
      if (q_masked) begin
         // Anything still waiting when the queue fills is lost with the mask
         next_s.pending = '0;
      end else begin
         next_s.pending = (s.pending & ~(push_ready ? taken : '0)) | fresh;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   pie_queue u_queue (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .push_valid(push_valid),
      .push_event(push_event),
      .push_ready(push_ready),
      .service_done(service_done),
      .main_resumed(main_resumed),
      .head_event(irq_event),
      .level(queue_level),
      .masked(q_masked),
      .busy(irq_pending)
   );

   assign queue_masked = q_masked;
endmodule

/* File: rtl/pie_cfg.svh */
// Constants for the interrupt event source block
// Overview of operation
// - Three millisecond timers raise events 26, 27 and 28 when their interval elapses.
// - Timer enable changes never touch timer events already queued.
// - A re-enabled timer restarts its elapsed count from zero.
// - Inputs 0-7 raise events 0-7 on rise, 10-17 on fall.
// - One enable per input gates both its rising and falling events.
// - Input edges are seen at up to 1 kHz; faster ones may vanish.
// - Edge events need both global enable and their input enable.
// - Counter compare matches raise events 20-25 when globally and locally enabled.
// - Pulse train completion raises event 18 or 19 when enabled.
// - Supply loss raises the power-fail event when enabled.
// - Each serial port has four separately enabled event sources.
// - Port 0 uses 30-33, port 1 34-37, port 2 8, 9, 38, 39.
// - Clearing a serial enable keeps its already queued events.
// - Frame events fire when a frame transmit or receive completes.
// - Serial events appear only in free-format protocol mode.
// - Enabled events enter an eight-entry FIFO, popped from head on service completion.
// - A full queue masks new events until drained and main program resumed.
`ifndef PIE_CFG_SVH
`define PIE_CFG_SVH

`define PIE_NUM_EVENTS 40
`define PIE_EVT_W 6
`define PIE_QUEUE_DEPTH 8
`define PIE_LEVEL_W 4
`define PIE_INTERVAL_W 16
`define PIE_PRESCALE_W 16
`define PIE_NUM_INPUTS 8
`define PIE_NUM_TIMERS 3
`define PIE_NUM_COUNTERS 6

`define PIE_CLK_NS 100
`define PIE_MS_NS 1000000
`define PIE_TICK_CYCLES ((`PIE_MS_NS) / (`PIE_CLK_NS))

`define PIE_EVT_RISE_BASE 0
`define PIE_EVT_FALL_BASE 10
`define PIE_EVT_P2_CHAR_TX 8
`define PIE_EVT_P2_CHAR_RX 9
`define PIE_EVT_PULSE0 18
`define PIE_EVT_PULSE1 19
`define PIE_EVT_COUNTER_BASE 20
`define PIE_EVT_TIMER_BASE 26
`define PIE_EVT_POWER 29
`define PIE_EVT_PORT0_BASE 30
`define PIE_EVT_PORT_STRIDE 4
`define PIE_EVT_P2_FRAME_TX 38
`define PIE_EVT_P2_FRAME_RX 39

`define PIE_RESET_EVT 6'h00
`define PIE_RESET_LEVEL 4'h0
`define PIE_RESET_COUNT 16'h0000

`endif

/* File: rtl/pie_pkg.sv */
// Types shared by the interrupt event source modules
`include "pie_cfg.svh"
package pie_pkg;

   typedef logic [`PIE_EVT_W-1:0] pie_evt_type;

   typedef struct packed {
      logic [`PIE_INTERVAL_W-1:0] count;
      logic armed;
      logic fire;
   } pie_timer_state_type;

   typedef struct packed {
      logic [`PIE_QUEUE_DEPTH-1:0][`PIE_EVT_W-1:0] entry;
      logic [`PIE_LEVEL_W-1:0] level;
      logic masked;
      logic busy;
   } pie_queue_state_type;

   typedef struct packed {
      logic [`PIE_PRESCALE_W-1:0] prescale;
      logic tick;
      logic [`PIE_NUM_INPUTS-1:0] din_seen;
      logic power_seen;
      logic [`PIE_NUM_EVENTS-1:0] pending;
   } pie_top_state_type;

endpackage

/* File: rtl/pie_timer.sv */
// One periodic millisecond timer event source
`timescale 1ns/100ps
`include "pie_cfg.svh"
module pie_timer
   import pie_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Control
   input wire logic tick,
   input wire logic enable,
   input wire logic [`PIE_INTERVAL_W-1:0] interval,
   // Event
   output logic fire
);
   pie_timer_state_type s;
   pie_timer_state_type next_s;
   logic [`PIE_INTERVAL_W:0] bumped;

   always_comb begin
      next_s = s;
      next_s.fire = 1'b0;
      next_s.armed = enable;
      bumped = {1'b0, s.count} + {{`PIE_INTERVAL_W{1'b0}}, 1'b1};
      if (!enable || !s.armed) begin
         next_s.count = `PIE_RESET_COUNT;
      end else if (tick) begin
         if (interval != '0 && bumped >= {1'b0, interval}) begin
            next_s.fire = 1'b1;
            next_s.count = `PIE_RESET_COUNT;
         end else if (!bumped[`PIE_INTERVAL_W]) begin
            next_s.count = bumped[`PIE_INTERVAL_W-1:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign fire = s.fire;
endmodule

/* File: rtl/pie_queue.sv */
// Eight-entry shifting request queue with full mask
`timescale 1ns/100ps
`include "pie_cfg.svh"
module pie_queue
   import pie_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Push side
   input wire logic push_valid,
   input wire logic [`PIE_EVT_W-1:0] push_event,
   output logic push_ready,
   // Service side
   input wire logic service_done,
   input wire logic main_resumed,
   output logic [`PIE_EVT_W-1:0] head_event,
   output logic [`PIE_LEVEL_W-1:0] level,
   output logic masked,
   output logic busy
);
   pie_queue_state_type s;
   pie_queue_state_type next_s;
   logic pop;
   logic push;
   logic [`PIE_LEVEL_W-1:0] after_pop;

   // Full implies masked, so the mask alone refuses pushes
   assign push_ready = !s.masked;

   always_comb begin
      next_s = s;
      pop = service_done && s.level != `PIE_RESET_LEVEL;
      push = push_valid && !s.masked;
      after_pop = s.level;
      if (pop) begin
         // Head removed only when its service completes; the rest move up
         for (int i = 0; i < `PIE_QUEUE_DEPTH - 1; i++) begin
            next_s.entry[i] = s.entry[i+1];
         end
         next_s.entry[`PIE_QUEUE_DEPTH-1] = `PIE_RESET_EVT;
         after_pop = s.level - 4'h1;
      end
      if (push) begin
         next_s.entry[after_pop[2:0]] = push_event;
      end
      next_s.level = after_pop + {3'h0, push};
      if (next_s.level == 4'h8) begin
         next_s.masked = 1'b1;
      end else if (s.masked && s.level == `PIE_RESET_LEVEL && main_resumed) begin
         next_s.masked = 1'b0;
      end
      next_s.busy = next_s.level != `PIE_RESET_LEVEL;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign head_event = s.entry[0];
   assign level = s.level;
   assign masked = s.masked;
   assign busy = s.busy;
endmodule

/* File: test/pie_top_properties.sv */
// Queue and mask checks bound onto the event source top
`timescale 1ns/100ps
`include "pie_cfg.svh"
module pie_top_properties (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Watched sources
   input wire logic global_irq_enable,
   input wire logic pulse0_done,
   input wire logic pulse0_done_enable,
   // Service and queue
   input wire logic service_done,
   input wire logic main_resumed,
   input wire logic irq_pending,
   input wire logic [`PIE_EVT_W-1:0] irq_event,
   input wire logic [`PIE_LEVEL_W-1:0] queue_level,
   input wire logic queue_masked
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_req18;
      pulse0_done && pulse0_done_enable && global_irq_enable && !queue_masked
         && queue_level == 0;
   endsequence
   // Lower pending numbers may each cost one cycle
   sequence s_seen18;
      ##[2:21] (irq_pending || queue_masked);
   endsequence
   sequence s_release;
      queue_masked && queue_level == 0 && main_resumed;
   endsequence
   sequence s_pop;
      service_done && queue_level != 0;
   endsequence
   sequence s_hold;
      queue_masked && !(queue_level == 0 && main_resumed);
   endsequence
   AST_PULSE_QUEUED: assert property (s_req18 |-> s_seen18)
      else $error("pulse done event not queued in time");
   AST_LEVEL_MAX: assert property (queue_level <= 8)
      else $error("queue level above depth");
   AST_PENDING_LEVEL: assert property (irq_pending == (queue_level != 0))
      else $error("pending flag disagrees with level");
   AST_EMPTY_EVENT: assert property (!irq_pending |-> irq_event == 0)
      else $error("head event not zero when empty");
   AST_POP: assert property (s_pop |=> queue_level <= $past(queue_level))
      else $error("service did not pop head");
   AST_FULL_MASK: assert property (queue_level == 8 |-> queue_masked)
      else $error("full queue not masked");
   AST_MASK_HOLD: assert property (s_hold |=> queue_masked)
      else $error("mask dropped early");
   AST_MASK_CLEAR: assert property (s_release |=> !queue_masked)
      else $error("mask not released");
   AST_MASK_DROP: assert property (queue_masked |=> queue_level <= $past(queue_level))
      else $error("event entered masked queue");
   AST_ONE_PUSH: assert property (queue_level <= $past(queue_level) + 1)
      else $error("more than one push per cycle");
endmodule
bind pie_top pie_top_properties pie_top_properties_i (.mclk, .rst, .global_irq_enable,
   .pulse0_done, .pulse0_done_enable, .service_done, .main_resumed, .irq_pending,
   .irq_event, .queue_level, .queue_masked);

/* File: test/pie_soft_model.sv */
// Service program model popping queued requests
`timescale 1ns/100ps
module pie_soft_model #(
   parameter int SERVICE_CYCLES = 3
)(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Control and queue view
   input wire logic run,
   input wire logic irq_pending,
   // Service handshake
   output logic service_done,
   output logic main_resumed
);
   int cnt;
   logic due;
   assign due = run && irq_pending && !service_done && cnt == SERVICE_CYCLES;
   // Handlers stay short and never restart a transmission
   always_ff @(posedge mclk) begin
      main_resumed <= run && !irq_pending;
      service_done <= !rst && due;
      if (rst || !run || !irq_pending || service_done || due) begin
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

/* File: test/pie_top_tb.sv */
// Self-checking bench for the interrupt event source block
`timescale 1ns/100ps
`include "pie_cfg.svh"
module pie_top_tb import pie_pkg::*; ;
   logic mclk, rst, ce, run, global_irq_enable;
   logic [15:0] timer0_interval, timer1_interval, timer2_interval;
   logic timer0_event_enable, timer1_event_enable, timer2_event_enable;
   logic [7:0] digital_input, input_edge_enable;
   logic [5:0] counter_match, irq_event;
   logic counter_match_enable, pulse0_done, pulse1_done, pulse0_done_enable;
   logic pulse1_done_enable, power_loss, power_fail_enable;
   logic [2:0] free_format_mode, char_tx_done, char_rx_done, frame_tx_done, frame_rx_done;
   logic [11:0] pen;
   logic service_done, main_resumed, irq_pending, queue_masked;
   logic [3:0] queue_level;
   int bad_count, n_compared;
   pie_evt_type got[$];

   pie_top #(.TICK_CYCLES(10)) pie_top_i (.mclk, .rst, .ce, .global_irq_enable,
      .timer0_interval, .timer1_interval, .timer2_interval, .timer0_event_enable,
      .timer1_event_enable, .timer2_event_enable, .digital_input, .input_edge_enable,
      .counter_match, .counter_match_enable, .pulse0_done, .pulse1_done,
      .pulse0_done_enable, .pulse1_done_enable, .power_loss, .power_fail_enable,
      .free_format_mode, .char_tx_done, .char_rx_done, .frame_tx_done, .frame_rx_done,
      .port0_char_tx_enable(pen[0]), .port0_char_rx_enable(pen[1]),
      .port0_frame_tx_enable(pen[2]), .port0_frame_rx_enable(pen[3]),
      .port1_char_tx_enable(pen[4]), .port1_char_rx_enable(pen[5]),
      .port1_frame_tx_enable(pen[6]), .port1_frame_rx_enable(pen[7]),
      .port2_char_tx_enable(pen[8]), .port2_char_rx_enable(pen[9]),
      .port2_frame_tx_enable(pen[10]), .port2_frame_rx_enable(pen[11]),
      .service_done, .main_resumed, .irq_pending, .irq_event, .queue_level, .queue_masked);

   pie_soft_model pie_soft_model_i (.mclk, .rst, .run, .irq_pending, .service_done,
      .main_resumed);

   always #50 mclk = ~mclk;

   // Head seen at each pop, in service order
   always @(posedge mclk) begin
      if (ce && service_done && irq_pending) begin
         got.push_back(irq_event);
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic strobe;
      @(posedge mclk);
      {char_tx_done, char_rx_done, frame_tx_done, frame_rx_done} <= 12'h000;
      {counter_match, pulse0_done, pulse1_done} <= 8'h00;
   endtask

   task automatic drain(input pie_evt_type exp[$]);
      int i;
      run <= 1'b1;
      for (i = 0; i < 400 && (irq_pending !== 1'b0 || queue_masked !== 1'b0); i++) begin
         @(posedge mclk);
      end
      cyc(2);
      run <= 1'b0;
      chk(queue_masked, 8'h00);
      chk(got.size(), exp.size());
      foreach (exp[k]) chk(got[k], exp[k]);
      got.delete();
   endtask

   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      cyc(20000);
      bad_count++;
      end_of_test();
   end

   initial begin
      pie_evt_type exp[$];
      {mclk, run, global_irq_enable, timer0_interval, timer1_interval, timer2_interval,
         timer0_event_enable, timer1_event_enable, timer2_event_enable, digital_input,
         input_edge_enable, counter_match, counter_match_enable, pulse0_done, pulse1_done,
         pulse0_done_enable, pulse1_done_enable, power_loss, power_fail_enable,
         free_format_mode, char_tx_done, char_rx_done, frame_tx_done, frame_rx_done,
         pen, bad_count, n_compared} = '0;
      rst = 1'b1;
      ce = 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(1);
      global_irq_enable <= 1'b1;
      pulse0_done_enable <= 1'b1;
      pulse0_done <= 1'b1;
      pulse1_done <= 1'b1;
      // Disabled counter and serial sources must stay out of the queue
      counter_match <= 6'h3f;
      frame_rx_done <= 3'h7;
      strobe();
      @(posedge mclk);
      #1;
      chk(queue_level, 8'h01);
      chk(irq_event, 8'h12);
      drain('{6'h12});
      // Every counter, pulse and serial source at once: only the lowest eight survive the mask
      pen <= 12'hfff;
      free_format_mode <= 3'h7;
      counter_match_enable <= 1'b1;
      pulse1_done_enable <= 1'b1;
      @(posedge mclk);
      {char_tx_done, char_rx_done, frame_tx_done, frame_rx_done} <= 12'hfff;
      {counter_match, pulse0_done, pulse1_done} <= 8'hff;
      strobe();
      cyc(12);
      #1;
      chk(queue_masked, 8'h01);
      drain('{6'h08, 6'h09, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17});
      free_format_mode <= 3'h3;
      {char_tx_done, char_rx_done, frame_tx_done, frame_rx_done} <= 12'hfff;
      strobe();
      cyc(12);
      drain('{6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25});
      pen <= 12'hc04;
      free_format_mode <= 3'h7;
      power_fail_enable <= 1'b1;
      power_loss <= 1'b1;
      {char_tx_done, char_rx_done, frame_tx_done, frame_rx_done} <= 12'hfff;
      counter_match <= 6'h30;
      strobe();
      cyc(12);
      pen <= 12'h000;
      cyc(3);
      drain('{6'h18, 6'h19, 6'h1d, 6'h20, 6'h26, 6'h27});
      // Slow single-edge toggles, input 7 left disabled
      run <= 1'b1;
      input_edge_enable <= 8'h7f;
      global_irq_enable <= 1'b0;
      digital_input[3] <= 1'b1;
      cyc(30);
      digital_input[3] <= 1'b0;
      cyc(30);
      global_irq_enable <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         digital_input[i] <= 1'b1;
         cyc(30);
         digital_input[i] <= 1'b0;
         cyc(30);
         if (i < 7) begin
            exp.push_back(i[5:0]);
            exp.push_back(6'h0a + i[5:0]);
         end
      end
      drain(exp);
      run <= 1'b1;
      timer0_interval <= 16'h0005;
      timer0_event_enable <= 1'b1;
      cyc(160);
      timer0_event_enable <= 1'b0;
      cyc(5);
      drain('{6'h1a, 6'h1a, 6'h1a});
      run <= 1'b1;
      timer1_interval <= 16'h0005;
      timer1_event_enable <= 1'b1;
      cyc(40);
      timer1_event_enable <= 1'b0;
      cyc(2);
      timer1_event_enable <= 1'b1;
      cyc(40);
      timer1_event_enable <= 1'b0;
      cyc(5);
      chk(got.size(), 8'h00);
      timer2_interval <= 16'h0005;
      timer2_event_enable <= 1'b1;
      run <= 1'b0;
      cyc(130);
      timer2_event_enable <= 1'b0;
      cyc(20);
      // Clock enable low: service strobes arrive but nothing may pop
      ce <= 1'b0;
      run <= 1'b1;
      cyc(20);
      #1;
      chk(queue_level, 8'h02);
      chk(got.size(), 8'h00);
      ce <= 1'b1;
      drain('{6'h1c, 6'h1c});
      end_of_test();
   end
endmodule
